// file: verilog/pulse_width_timer.sv
// pulse width measurement and single pulse emission on selectable pins
// Operation
// - widths counted in ticks of eight 7.3728 MHz base clock periods.
// - level bit 1 selects high pulse, 0 selects low pulse.
// - measure waits for selected level, then counts until level ends or timeout.
// - signed mode reports valid widths from 0 to 32767 ticks, and only below the signed timeout count.
// - signed mode gives up near 35.5 ms and reports zero.
// - extended mode spans up to 71.1 ms, times out near 71 ms reporting zero.
// - emit drives selected level for programmed ticks, then restores opposite level.
// - completion of emit signalled only after whole pulse has been output.
// - pin 0 selected makes emit a pure delay touching no pin.
// - active operation holds off timekeeping tick; beyond 1800 ticks time is lost.
`timescale 1ns/1ps
`include "pulse_timer_defs.svh"
module pulse_width_timer #(
  parameter int PINS      = 16,
  parameter int PIN_BITS  = 8,
  parameter int SIGNED_TO = `SIGNED_TIMEOUT,
  parameter int EXT_TO    = `EXT_TIMEOUT
) (
  input  wire logic                clock_i,
  input  wire logic                nrst_i,
  input  wire logic                measure_start_i,
  input  wire logic                measure_ext_i,
  input  wire logic                emit_start_i,
  input  wire logic [PIN_BITS-1:0] pin_sel_i,
  input  wire logic                level_i,
  input  wire logic [15:0]         emit_width_i,
  input  wire logic                rtc_tick_i,
  input  wire logic [PINS:1]       pin_in_i,
  output logic      [PINS:1]       pin_out_o,
  output logic      [PINS:1]       pin_oe_n_o,
  output logic                     busy_o,
  output logic                     done_o,
  output logic      [15:0]         width_count_o,
  output logic                     timeout_o,
  output logic                     rtc_tick_o,
  output logic                     rtc_lost_o
);
  // refuse sizes that the select and the 16-bit counters cannot serve
  if (PINS < 1 || PINS >= (1 << PIN_BITS)) begin : g_bad_pins
    $error("pin count does not fit pin select");
  end
  if (PIN_BITS < 1 || PIN_BITS > 16) begin : g_bad_sel
    $error("pin select width out of range");
  end
  if (SIGNED_TO < 1 || SIGNED_TO > 65535) begin : g_bad_signed
    $error("signed timeout out of range");
  end
  if (EXT_TO < 1 || EXT_TO > 65535) begin : g_bad_ext
    $error("extended timeout out of range");
  end
  if (`TICK_CYC < 1) begin : g_bad_tick
    $error("tick shorter than one clock");
  end

  typedef struct packed {
    pulse_timer_pkg::state_t st;
    logic [PIN_BITS-1:0]     pin;
    logic                    level;
    logic                    ext;
    logic                    emitting;
    logic [15:0]             cnt;
    logic [15:0]             limit;
    logic [15:0]             width;
    logic                    timeout;
    logic                    done;
    logic                    lost;
    logic [15:0]             held;
    logic [PINS:1]           drive;
    logic [PINS:1]           oe_n;
  } timer_state_t;

  localparam logic [15:0] SIGNED_LIMIT = 16'(SIGNED_TO);
  localparam logic [15:0] EXT_LIMIT    = 16'(EXT_TO);
  localparam logic [15:0] SIGNED_CAP   = 16'(`SIGNED_MAX);
  // one past the safe count, so an operation of exactly that length is still clean
  localparam logic [15:0] HELD_LIMIT   = 16'(`RTC_SAFE_TICKS + 1);
  localparam logic [15:0] CNT_STEP     = 16'h0001;

  // reset image: nothing driven, every enable released
  localparam timer_state_t RESET_STATE = '{
    st:       pulse_timer_pkg::ST_IDLE,
    pin:      '0,
    level:    `LEVEL_LOW,
    ext:      1'b0,
    emitting: 1'b0,
    cnt:      '0,
    limit:    '0,
    width:    '0,
    timeout:  1'b0,
    done:     1'b0,
    lost:     1'b0,
    held:     '0,
    drive:    '0,
    oe_n:     '1
  };

  timer_state_t s_q;
  timer_state_t s_d;
  logic         tick;
  logic         restart;
  logic [PINS:1] pin_sync;
  logic         pin_level;
  logic          accept;
  logic          op_active;
  logic [PINS:1] sel_mask;
  logic [PINS:1] cur_mask;

  // one-hot select of a physical pin, zero for the dummy pin
  function automatic logic [PINS:1] pin_mask(input logic [PIN_BITS-1:0] sel);
    logic [PINS:1] m;
    m = '0;
    for (int i = 1; i <= PINS; i++) begin
      if (sel == PIN_BITS'(i)) m[i] = 1'b1;
    end
    return m;
  endfunction

  // new drive image in which only the masked pins take the level
  function automatic logic [PINS:1] drive_pin(input logic [PINS:1] old, input logic [PINS:1] mask,
                                              input logic lvl);
    return (old & ~mask) | ({PINS{lvl}} & mask);
  endfunction

  genvar g;
  generate
    for (g = 1; g <= PINS; g++) begin : g_sync
      pin_sync u_sync (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .async_i (pin_in_i[g]),
        .sync_o  (pin_sync[g])
      );
    end
  endgenerate

  tick_divider #(
    .DIV (`TICK_CYC)
  ) u_tick (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .restart_i (restart),
    .tick_o    (tick)
  );

  assign sel_mask = pin_mask(pin_sel_i);
  assign cur_mask = pin_mask(s_q.pin);
  assign pin_level = |(pin_sync & cur_mask);
  // requests taken only from idle; starts while busy are dropped silently
  assign accept = (s_q.st == pulse_timer_pkg::ST_IDLE) && (measure_start_i || emit_start_i);
  // states in which the pin is watched or driven
  assign op_active = (s_q.st == pulse_timer_pkg::ST_WAIT_LEVEL) || (s_q.st == pulse_timer_pkg::ST_MEASURE) ||
                     (s_q.st == pulse_timer_pkg::ST_EMIT);
  // prescaler restarts on each accepted request
  assign restart = accept;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      pulse_timer_pkg::ST_IDLE: begin
        if (measure_start_i) begin
          s_d.pin = pin_sel_i;
          s_d.level = level_i;
          s_d.ext = measure_ext_i;
          s_d.emitting = 1'b0;
          s_d.cnt = '0;
          s_d.limit = measure_ext_i ? EXT_LIMIT : SIGNED_LIMIT;
          s_d.st = pulse_timer_pkg::ST_WAIT_LEVEL;
        end else if (emit_start_i) begin
          s_d.pin = pin_sel_i;
          s_d.level = level_i;
          s_d.emitting = 1'b1;
          s_d.cnt = '0;
          s_d.limit = emit_width_i;
          // dummy pin leaves every pin untouched
          // drive selected level on chosen pin
          s_d.drive = drive_pin(s_q.drive, sel_mask, level_i);
          s_d.oe_n = s_q.oe_n & ~sel_mask;
          s_d.st = pulse_timer_pkg::ST_EMIT;
        end
      end
      pulse_timer_pkg::ST_WAIT_LEVEL: begin
        // wait for selected level, timeout still runs
        if (pin_level == s_q.level) begin
          s_d.st = pulse_timer_pkg::ST_MEASURE;
        end else if (tick) begin
          s_d.cnt = s_q.cnt + 16'h0001;
          if (s_d.cnt >= s_q.limit) begin
            s_d.width = '0;
            s_d.timeout = 1'b1;
            s_d.st = pulse_timer_pkg::ST_DONE;
          end
        end
        if (pin_level == s_q.level) s_d.cnt = '0;
      end
      pulse_timer_pkg::ST_MEASURE: begin
        if (pin_level != s_q.level) begin
          s_d.width = s_q.cnt;
          s_d.timeout = 1'b0;
          s_d.st = pulse_timer_pkg::ST_DONE;
        end else if (tick) begin
          s_d.cnt = s_q.cnt + 16'h0001;
          if (s_d.cnt >= s_q.limit ||
              (!s_q.ext && s_d.cnt > SIGNED_CAP)) begin
            s_d.width = '0;
            s_d.timeout = 1'b1;
            s_d.st = pulse_timer_pkg::ST_DONE;
          end
        end
      end
      pulse_timer_pkg::ST_EMIT: begin
        // width zero is out of range, treated as one tick
        if (tick) begin
          s_d.cnt = s_q.cnt + 16'h0001;
          if (s_d.cnt >= s_q.limit) begin
            s_d.drive = drive_pin(s_q.drive, cur_mask, ~s_q.level);
            s_d.width = s_q.limit;
            s_d.timeout = 1'b0;
            s_d.st = pulse_timer_pkg::ST_DONE;
          end
        end
      end
      pulse_timer_pkg::ST_DONE: begin
        // done only once the pulse has fully ended
        s_d.done = 1'b1;
        s_d.st = pulse_timer_pkg::ST_IDLE;
      end
      default: begin
        // unreachable code: fall back to idle, pin drive kept
        s_d.st = pulse_timer_pkg::ST_IDLE;
      end
    endcase
    // any tick gated off while busy, done cycle included, is lost
    if (s_q.st != pulse_timer_pkg::ST_IDLE && (rtc_tick_i || s_q.held == HELD_LIMIT)) begin
      s_d.lost = 1'b1;
    end else if (accept) begin
      s_d.lost = 1'b0;
    end
    // operation past the safe tick count also loses time
    if (accept) begin
      s_d.held = '0;
    end else if (tick && op_active && s_q.held != HELD_LIMIT) begin
      s_d.held = s_q.held + CNT_STEP;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out_o = s_q.drive;
  assign pin_oe_n_o = s_q.oe_n;
  assign busy_o = (s_q.st != pulse_timer_pkg::ST_IDLE);
  assign done_o = s_q.done;
  assign width_count_o = s_q.width;
  assign timeout_o = s_q.timeout;
  // timekeeping tick held off while busy
  assign rtc_tick_o = rtc_tick_i && !busy_o;
  assign rtc_lost_o = s_q.lost;
endmodule

// file: verilog/pulse_timer_defs.svh
// timing constants and field values for the pulse width timer
`ifndef PULSE_TIMER_DEFS_SVH
`define PULSE_TIMER_DEFS_SVH
`define CLK_HZ            10000000
`define BASE_HZ           7372800
`define BASE_PER_TICK     8
// tick period in ns, rounded down, at least one clock
`define TICK_NS           ((`BASE_PER_TICK * 1000000) / (`BASE_HZ / 1000))
`define TICK_CYC          ((`TICK_NS * (`CLK_HZ / 1000000)) / 1000)
`define LEVEL_HIGH        1'b1
`define LEVEL_LOW         1'b0
`define DUMMY_PIN         8'h00
`define SIGNED_MAX        32'h00007fff
`define SIGNED_TIMEOUT_US 35500
`define EXT_TIMEOUT_US    71000
`define SIGNED_TIMEOUT    ((`SIGNED_TIMEOUT_US * 1000) / `TICK_NS)
`define EXT_TIMEOUT       ((`EXT_TIMEOUT_US * 1000) / `TICK_NS)
`define RTC_SAFE_TICKS    1800
`endif

// file: verilog/pulse_timer_pkg.sv
// types shared by the pulse width timer files
package pulse_timer_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_LEVEL,
    ST_MEASURE,
    ST_EMIT,
    ST_DONE
  } state_t;
endpackage

// file: verilog/tick_divider.sv
// prescaler giving one-cycle tick enables, restartable
`timescale 1ns/1ps
module tick_divider #(
  parameter int DIV = 10
) (
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic restart_i,
  output logic      tick_o
);
  if (DIV < 1 || DIV > 65536) begin : g_bad_div
    $error("tick divider out of range");
  end
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } div_state_t;
  div_state_t s_q;
  div_state_t s_d;
  localparam logic [15:0] LAST = 16'(DIV - 1);
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart_i) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == LAST) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick_o = s_q.tick;
endmodule

// file: verilog/pin_sync.sv
// two-stage synchroniser for one input pin level, one instance per pin
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_t;
  sync_state_t s_q;
  sync_state_t s_d;
  always_comb begin
    s_d.meta = async_i;
    s_d.stable = s_q.meta;
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign sync_o = s_q.stable;
endmodule

// file: bench/pulse_width_timer_checker.sv
// port-level assertions for the pulse width timer
`timescale 1ns/1ps
module pulse_width_timer_checker #(
  parameter int PINS      = 16,
  parameter int PIN_BITS  = 8,
  parameter int SIGNED_TO = 50,
  parameter int EXT_TO    = 100
) (
  input wire logic                clock_i,
  input wire logic                nrst_i,
  input wire logic                measure_start_i,
  input wire logic                emit_start_i,
  input wire logic [PIN_BITS-1:0] pin_sel_i,
  input wire logic                rtc_tick_i,
  input wire logic [PINS:1]       pin_out_o,
  input wire logic [PINS:1]       pin_oe_n_o,
  input wire logic                busy_o,
  input wire logic                done_o,
  input wire logic [15:0]         width_count_o,
  input wire logic                timeout_o,
  input wire logic                rtc_tick_o,
  input wire logic                rtc_lost_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic emit_go;
  assign emit_go = emit_start_i && !busy_o && !measure_start_i;
  AST_RTC_GATE: assert property (busy_o |-> !rtc_tick_o)
    else $error("tick passed while busy");
  AST_RTC_PASS: assert property (!busy_o |-> rtc_tick_o == rtc_tick_i)
    else $error("tick not passed while idle");
  AST_RTC_LOST: assert property (busy_o && rtc_tick_i |=> rtc_lost_o)
    else $error("held tick not flagged");
  AST_DONE_PULSE: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  AST_EMIT_BUSY: assert property (emit_go |=> busy_o)
    else $error("emit not started");
  AST_EMIT_MIN: assert property (emit_go |=> !done_o [*8])
    else $error("emit done before one tick");
  AST_DUMMY: assert property (emit_go && pin_sel_i == '0 |=> ($stable(pin_out_o) && $stable(pin_oe_n_o)) [*8])
    else $error("dummy pin touched a pin");
  AST_DONE_IDLE: assert property (done_o |-> ##[0:1] !busy_o)
    else $error("busy after done");
  AST_TMO_ZERO: assert property (done_o && timeout_o |-> width_count_o == 16'h0000)
    else $error("timeout width not zero");
  AST_VALID_NZ: assert property (done_o && !timeout_o |-> width_count_o != 16'h0000)
    else $error("valid width is zero");
  cover property (done_o && timeout_o);
  cover property (done_o && !timeout_o);
  cover property (busy_o && rtc_tick_i);
endmodule
bind pulse_width_timer pulse_width_timer_checker #(.PINS(PINS), .PIN_BITS(PIN_BITS), .SIGNED_TO(SIGNED_TO),
  .EXT_TO(EXT_TO)) chk_i (.clock_i, .nrst_i, .measure_start_i, .emit_start_i, .pin_sel_i, .rtc_tick_i,
  .pin_out_o, .pin_oe_n_o, .busy_o, .done_o, .width_count_o, .timeout_o, .rtc_tick_o, .rtc_lost_o);

// file: bench/pin_source.sv
// external signal source and load on the timer pins
`timescale 1ns/1ps
module pin_source (
  input  wire logic        clock_i,
  input  wire logic [16:1] out_i,
  input  wire logic [16:1] oe_n_i,
  output logic      [16:1] pin_o
);
  logic [16:1] src_lvl = 16'h0000;
  // driven pins follow the timer, others the source
  assign pin_o = (oe_n_i & src_lvl) | (~oe_n_i & out_i);
  task automatic pulse(input int p, input logic l, input int pre, input int len);
    src_lvl[p] = !l;
    repeat (pre) @(negedge clock_i);
    src_lvl[p] = l;
    repeat (len) @(negedge clock_i);
    src_lvl[p] = !l;
  endtask
endmodule

// file: bench/tb_pulse_width_timer.sv
// self-checking bench for the pulse width timer
`timescale 1ns/1ps
module tb_pulse_width_timer;
  localparam int STO = 50;
  localparam int ETO = 100;
  logic        clock_i, nrst_i, ms, mx, es, lvl, rtc, busy, done, tmo, rtc_o, lost;
  logic [7:0]  sel;
  logic [15:0] w, cnt;
  logic [16:1] pin_w, out, oe_n;
  int          fail_count, checks, cyc;
  pin_source src (.clock_i, .out_i(out), .oe_n_i(oe_n), .pin_o(pin_w));
  pulse_width_timer #(.SIGNED_TO(STO), .EXT_TO(ETO)) dut (.clock_i, .nrst_i, .measure_start_i(ms),
    .measure_ext_i(mx), .emit_start_i(es), .pin_sel_i(sel), .level_i(lvl), .emit_width_i(w), .rtc_tick_i(rtc),
    .pin_in_i(pin_w), .pin_out_o(out), .pin_oe_n_o(oe_n), .busy_o(busy), .done_o(done), .width_count_o(cnt),
    .timeout_o(tmo), .rtc_tick_o(rtc_o), .rtc_lost_o(lost));
  initial begin
    clock_i = 0;
    forever #50 clock_i = ~clock_i;
  end
  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic run(input logic m, x, e, input logic [7:0] p, input logic l, input logic [15:0] wd);
    @(negedge clock_i);
    ms = m; mx = x; es = e; sel = p; lvl = l; w = wd;
    @(negedge clock_i);
    ms = 0; es = 0;
    chk(busy === 1'b1, "start not taken");
    cyc = 1;
    while (done !== 1'b1 && cyc < 3000) begin
      @(negedge clock_i);
      cyc++;
    end
    if (cyc >= 3000) begin
      chk(1'b0, "no done");
      complete_run();
    end
  endtask
  task automatic emit_case(input logic [7:0] p, input logic l, input logic [15:0] wd);
    fork
      run(0, 0, 1, p, l, wd);
      begin
        repeat (3) @(negedge clock_i);
        chk(oe_n[p] === 1'b0 && out[p] === l, "pulse level");
        es = 1;
        @(negedge clock_i);
        es = 0;
      end
    join
    chk(cyc >= wd * 10 && cyc <= wd * 10 + 4, "emit length");
    chk(out[p] === !l && cnt === wd, "trailing level");
  endtask
  task automatic delay_case();
    logic [16:1] o0, e0;
    o0 = out;
    e0 = oe_n;
    run(0, 0, 1, 8'h00, 1'b1, 16'h0003);
    chk(cyc >= 30 && cyc <= 34 && out === o0 && oe_n === e0, "dummy delay");
  endtask
  task automatic measure_case(input logic [7:0] p, input logic l, x, input int len);
    src.src_lvl[p] = !l;
    repeat (3) @(negedge clock_i);
    fork
      run(1, x, 0, p, l, 16'h0000);
      src.pulse(p, l, 5, len * 10);
    join
    chk(tmo === 1'b0 && cnt >= len - 1 && cnt <= len + 1, "measured width");
  endtask
  task automatic timeout_case(input logic x, input int to);
    rtc = 1;
    run(1, x, 0, 8'h07, 1'b1, 16'h0000);
    chk(tmo === 1'b1 && cnt === 16'h0000, "timeout result");
    chk(cyc >= to * 10 && cyc <= to * 10 + 8, "timeout length");
    @(negedge clock_i);
    chk(lost === 1'b1 && rtc_o === 1'b1, "tick hold-off");
    rtc = 0;
  endtask
  initial begin
    nrst_i = 0; ms = 0; mx = 0; es = 0; lvl = 0; rtc = 0; sel = 8'h00; w = 16'h0001;
    fail_count = 0;
    checks = 0;
    repeat (3) @(negedge clock_i);
    nrst_i = 1;
    chk(oe_n === 16'hffff && busy === 1'b0, "reset state");
    emit_case(8'h03, 1'b1, 16'h0005);
    emit_case(8'h10, 1'b0, 16'h0001);
    delay_case();
    measure_case(8'h05, 1'b1, 1'b0, 7);
    measure_case(8'h09, 1'b0, 1'b1, 12);
    timeout_case(1'b0, STO);
    timeout_case(1'b1, ETO);
    complete_run();
  end
endmodule
